// file: src/alias_match.sv
// Purpose: parallel alias comparator with lowest-index priority
// Assumes: alias table is presented flat, one 7-bit field per entry
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/100ps
module alias_match #(
  parameter int NUM_ENTRIES = alias_remap_pkg::MAX_ENTRIES,
  parameter int IDX_W       = (NUM_ENTRIES > 1) ? $clog2(NUM_ENTRIES) : 1
) (
  // alias table
  input  wire logic [NUM_ENTRIES-1:0][6:0] alias_tbl,
  // incoming address
  input  wire logic [6:0]                  probe_addr,
  // result
  output logic                             hit,
  output logic [IDX_W-1:0]                 hit_idx
);

  logic [NUM_ENTRIES-1:0] match;

  genvar g;
  generate
    for (g = 0; g < NUM_ENTRIES; g++) begin : g_cmp
      // zero alias means the entry is switched off
      assign match[g] = (alias_tbl[g] != alias_remap_pkg::ALIAS_OFF) &&
                        (alias_tbl[g] == probe_addr);
    end
  endgenerate

  // lowest index wins if software programs the same alias twice
  always_comb begin
    hit     = 1'b0;
    hit_idx = '0;
    for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
      if (match[i]) begin
        hit     = 1'b1;
        hit_idx = IDX_W'(i);
      end
    end
  end

endmodule : alias_match

// file: src/alias_remap_pkg.sv
// Purpose: shared constants for the remote i2c alias remap block
// Assumes: 8-bit register space reached over a plain strobe port
// Notes:   offsets below are the register addresses themselves
package alias_remap_pkg;

  localparam int          REG_ADDR_W   = 8;
  localparam int          REG_DATA_W   = 8;
  localparam int          I2C_ADDR_W   = 7;
  localparam int          MAX_ENTRIES  = 8;

  // address field sits in bits 7..1 of every table register
  localparam int          FIELD_LSB    = 1;
  localparam int          FIELD_MSB    = 7;

  // table bases; entry n sits at base + n
  localparam logic [7:0]  TARGET_BASE  = 8'h08;
  localparam logic [7:0]  ALIAS_BASE   = 8'h10;

  // printed offsets of the individually documented registers
  localparam logic [7:0]  TARGET_5_OFF = 8'h0d;
  localparam logic [7:0]  TARGET_6_OFF = 8'h0e;
  localparam logic [7:0]  TARGET_7_OFF = 8'h0f;
  localparam logic [7:0]  ALIAS_0_OFF  = 8'h10;
  localparam logic [7:0]  ALIAS_1_OFF  = 8'h11;

  localparam logic [7:0]  TABLE_RESET  = 8'h00;
  localparam logic [6:0]  ALIAS_OFF    = 7'h00;
  localparam logic [7:0]  UNMAPPED_RD  = 8'h00;

endpackage : alias_remap_pkg

// file: src/remote_i2c_alias_remap.sv
// Purpose: alias table, target table and address rewrite for remote i2c access
// Assumes: front end presents each transaction address as a one-cycle request
// Notes:   result appears one cycle after the request; no stall on either side
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
// Contract
// - target register holds 7-bit address, resets zero
// - alias hit forwards with target address substituted
// - alias register holds 7-bit decoder address
// - zero alias disables its entry entirely
// - alias n always maps to target n
// - target entries 0..4 share same layout
module remote_i2c_alias_remap #(
  parameter int NUM_ENTRIES = alias_remap_pkg::MAX_ENTRIES,
  parameter int IDX_W       = (NUM_ENTRIES > 1) ? $clog2(NUM_ENTRIES) : 1
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // incoming transaction address from the local i2c slave
  input  wire logic       req_valid,
  input  wire logic [6:0] req_addr,
  input  wire logic       req_rnw,
  // rewritten transaction toward the control channel
  output logic            fwd_valid,
  output logic      [6:0] fwd_addr,
  output logic            fwd_rnw,
  output logic            miss
);

  // entry_of slices the address, so the index width must fit the table exactly
  if (NUM_ENTRIES < 1 || NUM_ENTRIES > alias_remap_pkg::MAX_ENTRIES ||
      IDX_W != ((NUM_ENTRIES > 1) ? $clog2(NUM_ENTRIES) : 1)) begin : g_bad_param
    $error("NUM_ENTRIES or IDX_W out of range");
  end

  logic [NUM_ENTRIES-1:0][7:0] tgt_reg;
  logic [NUM_ENTRIES-1:0][6:0] alias_reg;
  logic [7:0]                  rdata_reg;
  logic                        fwd_valid_reg;
  logic [6:0]                  fwd_addr_reg;
  logic                        fwd_rnw_reg;
  logic                        miss_reg;
  logic                        hit;
  logic [IDX_W-1:0]            hit_idx;

  function automatic logic in_table(input logic [7:0] a, input logic [7:0] base);
    return (a >= base) && ({1'b0, a} < ({1'b0, base} + 9'(NUM_ENTRIES)));
  endfunction : in_table

  // bases are 8-aligned, so the low bits are the entry index
  function automatic logic [IDX_W-1:0] entry_of(input logic [7:0] a);
    return a[IDX_W-1:0];
  endfunction : entry_of

  // target table; bit 0 is a plain read/write spare bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        tgt_reg[i] <= alias_remap_pkg::TABLE_RESET;
      end
    end else if (reg_wr && in_table(reg_addr, alias_remap_pkg::TARGET_BASE)) begin
      tgt_reg[entry_of(reg_addr)] <= reg_wdata;
    end
  end

  // alias table; bit 0 is not stored and reads zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        alias_reg[i] <= alias_remap_pkg::ALIAS_OFF;
      end
    end else if (reg_wr && in_table(reg_addr, alias_remap_pkg::ALIAS_BASE)) begin
      alias_reg[entry_of(reg_addr)] <=
        reg_wdata[alias_remap_pkg::FIELD_MSB:alias_remap_pkg::FIELD_LSB];
    end
  end

  // read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= alias_remap_pkg::UNMAPPED_RD;
    end else if (reg_rd && in_table(reg_addr, alias_remap_pkg::TARGET_BASE)) begin
      rdata_reg <= tgt_reg[entry_of(reg_addr)];
    end else if (reg_rd && in_table(reg_addr, alias_remap_pkg::ALIAS_BASE)) begin
      rdata_reg <= {alias_reg[entry_of(reg_addr)], 1'b0};
    end else begin
      rdata_reg <= alias_remap_pkg::UNMAPPED_RD;
    end
  end

  alias_match #(
    .NUM_ENTRIES (NUM_ENTRIES),
    .IDX_W       (IDX_W)
  ) u_match (
    .alias_tbl  (alias_reg),
    .probe_addr (req_addr),
    .hit        (hit),
    .hit_idx    (hit_idx)
  );

  // rewrite path; the address holds after a forward so the channel may sample late
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fwd_valid_reg <= 1'b0;
      fwd_addr_reg  <= alias_remap_pkg::ALIAS_OFF;
      fwd_rnw_reg   <= 1'b0;
      miss_reg      <= 1'b0;
    end else begin
      fwd_valid_reg <= req_valid && hit;
      miss_reg      <= req_valid && !hit;
      if (req_valid && hit) begin
        fwd_addr_reg <=
          tgt_reg[hit_idx][alias_remap_pkg::FIELD_MSB:alias_remap_pkg::FIELD_LSB];
        fwd_rnw_reg  <= req_rnw;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign fwd_valid = fwd_valid_reg;
  assign fwd_addr  = fwd_addr_reg;
  assign fwd_rnw   = fwd_rnw_reg;
  assign miss      = miss_reg;

  // all checks stand down while reset is held
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_req_hit;
    req_valid && hit;
  endsequence

  sequence s_req_miss;
    req_valid && !hit;
  endsequence

  sequence s_tgt_wr;
    reg_wr && in_table(reg_addr, alias_remap_pkg::TARGET_BASE);
  endsequence

  sequence s_entry0_hit;
    req_valid && alias_reg[0] != alias_remap_pkg::ALIAS_OFF && req_addr == alias_reg[0];
  endsequence

  target_read_a: assert property (
    reg_rd && in_table(reg_addr, alias_remap_pkg::TARGET_BASE)
    |=> reg_rdata == $past(tgt_reg[entry_of(reg_addr)]))
    else $error("target read data wrong");

  hit_forward_a: assert property (
    s_req_hit |=> fwd_valid && !miss && fwd_rnw == $past(req_rnw))
    else $error("hit not forwarded");

  alias_read_a: assert property (
    reg_wr && in_table(reg_addr, alias_remap_pkg::ALIAS_BASE) ##1
    reg_rd && reg_addr == $past(reg_addr)
    |=> reg_rdata == {$past(reg_wdata[7:1], 2), 1'b0})
    else $error("alias write then read mismatch");

  zero_alias_a: assert property (
    req_valid && req_addr == alias_remap_pkg::ALIAS_OFF |=> !fwd_valid && miss)
    else $error("zero address forwarded");

  pair_index_a: assert property (
    s_req_hit ##0 (alias_reg[hit_idx] == req_addr)
    |=> fwd_addr == $past(tgt_reg[hit_idx][7:1]))
    else $error("alias mapped to wrong target");

  low_entry_a: assert property (
    reg_wr && reg_addr == alias_remap_pkg::TARGET_BASE ##1 reg_rd &&
    reg_addr == alias_remap_pkg::TARGET_BASE
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("target entry 0 layout wrong");

  miss_drop_a: assert property (
    s_req_miss |=> miss && !fwd_valid ##1 !miss || $past(req_valid))
    else $error("miss forwarded");

  idle_quiet_a: assert property (
    !req_valid |=> !fwd_valid && !miss)
    else $error("output without request");

  target_write_a: assert property (
    s_tgt_wr |=> tgt_reg[$past(entry_of(reg_addr))] == $past(reg_wdata))
    else $error("target write lost");

  alias_bit0_a: assert property (
    reg_rd && in_table(reg_addr, alias_remap_pkg::ALIAS_BASE) |=> reg_rdata[0] == 1'b0)
    else $error("alias spare bit not zero");

  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == alias_remap_pkg::UNMAPPED_RD)
    else $error("read data outside its cycle");

  unmapped_read_a: assert property (
    reg_rd && !in_table(reg_addr, alias_remap_pkg::TARGET_BASE) &&
    !in_table(reg_addr, alias_remap_pkg::ALIAS_BASE)
    |=> reg_rdata == alias_remap_pkg::UNMAPPED_RD)
    else $error("unmapped read not zero");

  hit_enabled_a: assert property (
    s_req_hit |-> alias_reg[hit_idx] != alias_remap_pkg::ALIAS_OFF)
    else $error("disabled entry matched");

  entry0_pair_a: assert property (
    s_entry0_hit |=> fwd_valid &&
    fwd_addr == $past(tgt_reg[0][alias_remap_pkg::FIELD_MSB:alias_remap_pkg::FIELD_LSB]))
    else $error("entry 0 not mapped to target 0");

  fwd_hold_a: assert property (
    !(req_valid && hit) |=> $stable(fwd_addr) && $stable(fwd_rnw))
    else $error("forward address moved without a hit");

  result_excl_a: assert property (
    !(fwd_valid && miss))
    else $error("forward and miss together");

endmodule : remote_i2c_alias_remap

// file: test/i2c_host_model.sv
// Purpose: local i2c host stand-in that issues transaction addresses
// Assumes: one request at a time on the single system clock
// Notes:   idle lines show the inverse of the last value, never a stale copy
`timescale 1ns/100ps
module i2c_host_model (
  // clock
  input  wire logic       sys_clk,
  // request toward the remap block
  output logic            req_valid,
  output logic      [6:0] req_addr,
  output logic            req_rnw
);
  initial begin
    req_valid = 1'b0;
    req_addr  = 7'h00;
    req_rnw   = 1'b0;
  end

  // called right after a rising edge; returns on the edge that takes the request
  task automatic send(input logic [6:0] a, input logic r);
    req_valid <= 1'b1;
    req_addr  <= a;
    req_rnw   <= r;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    req_addr  <= ~a;
    req_rnw   <= ~r;
  endtask : send
endmodule : i2c_host_model

// file: test/tb.sv
// Purpose: self-checking bench for the alias remap block
// Assumes: register port answers one cycle after the read strobe
// Notes:   fwd_addr and fwd_rnw are expected to hold the last hit on a miss
`timescale 1ns/100ps
module tb;
  typedef struct {logic [6:0] a; logic r; logic hit; logic [6:0] exp;} row_s;
  logic       sys_clk, rst, reg_wr, reg_rd, req_valid, req_rnw;
  logic       fwd_valid, fwd_rnw, miss, last_r;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [6:0] req_addr, fwd_addr, last_a;
  int         fail_count, total_checks, cycles;
  // alias 0x50+n pairs with target 0x30+n once the tables are loaded
  row_s rows [6] = '{'{7'h50, 1'b0, 1'b1, 7'h30}, '{7'h51, 1'b1, 1'b1, 7'h31},
                     '{7'h55, 1'b0, 1'b1, 7'h35}, '{7'h57, 1'b1, 1'b1, 7'h37},
                     '{7'h7f, 1'b0, 1'b0, 7'h00}, '{7'h30, 1'b1, 1'b0, 7'h00}};

  remote_i2c_alias_remap dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .req_valid(req_valid), .req_addr(req_addr), .req_rnw(req_rnw),
    .fwd_valid(fwd_valid), .fwd_addr(fwd_addr), .fwd_rnw(fwd_rnw), .miss(miss));
  i2c_host_model host (.sys_clk(sys_clk), .req_valid(req_valid), .req_addr(req_addr),
    .req_rnw(req_rnw));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // generous ceiling: the sequence needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t register read %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_fwd(input logic [9:0] exp);
    total_checks++;
    if ({fwd_valid, miss, fwd_addr, fwd_rnw} !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t forward result expected %h", $time, exp);
    end
  endtask : chk_fwd

  // bus tasks start right after a rising edge and return on one, so a read
  // may follow a write with no gap
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(negedge sys_clk);
    chk_reg(reg_rdata, exp);
    @(posedge sys_clk);
  endtask : rd

  task automatic send_chk(input logic [6:0] a, input logic r, input logic hit,
                          input logic [6:0] ea);
    host.send(a, r);
    @(negedge sys_clk);
    if (hit) begin
      last_a = ea;
      last_r = r;
    end
    chk_fwd({hit, ~hit, last_a, last_r});
    @(posedge sys_clk);
  endtask : send_chk

  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, last_a, last_r} = '0;
    rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h0d, 8'h00);
    rd(8'h11, 8'h00);
    send_chk(7'h00, 1'b0, 1'b0, 7'h00);
    for (int n = 0; n < 8; n++) begin
      wr(alias_remap_pkg::TARGET_BASE + 8'(n), 8'h61 + 8'(2 * n));
      rd(alias_remap_pkg::TARGET_BASE + 8'(n), 8'h61 + 8'(2 * n));
      wr(alias_remap_pkg::ALIAS_BASE + 8'(n), 8'ha1 + 8'(2 * n));
      rd(alias_remap_pkg::ALIAS_BASE + 8'(n), 8'ha0 + 8'(2 * n));
    end
    foreach (rows[i]) send_chk(rows[i].a, rows[i].r, rows[i].hit, rows[i].exp);
    // unmapped place must neither store nor answer
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    wr(8'h12, 8'h00);
    send_chk(7'h52, 1'b0, 1'b0, 7'h00);
    send_chk(7'h00, 1'b1, 1'b0, 7'h00);
    wr(8'h0e, 8'h7e);
    send_chk(7'h56, 1'b1, 1'b1, 7'h3f);
    // second reset clears both tables and the held forward fields
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    {last_a, last_r} = '0;
    rd(8'h0d, 8'h00);
    rd(8'h11, 8'h00);
    send_chk(7'h51, 1'b0, 1'b0, 7'h00);
    finish_test();
  end
endmodule : tb
